// ### otpa_pkg.sv
/*
 Package for the one-time-programmable access block: pin levels, option bit positions, timing counts.
 Assumes a single 100 MHz clock shared by both ends.
*/
package otpa_pkg;

   // ----------------------------------------------------------------
   // Pin levels and access modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OTPA_LVL_LOW,
      OTPA_LVL_HIGH,
      OTPA_LVL_HV
   } otpa_level_t;

   typedef enum logic [3:0] {
      OTPA_OP_IDLE,
      OTPA_OP_READ,
      OTPA_OP_PROGRAM,
      OTPA_OP_VERIFY,
      OTPA_OP_SET_PROTECT,
      OTPA_OP_SET_LOWNOISE,
      OTPA_OP_SET_LATCHDIS,
      OTPA_OP_SET_WDOG,
      OTPA_OP_SET_ACCDIS
   } otpa_op_t;

   // ----------------------------------------------------------------
   // Widths and option bit positions
   // ----------------------------------------------------------------
   localparam int OTPA_AW          = 10;
   localparam int OTPA_DW          = 8;
   localparam int OTPA_DEPTH       = 1024;
   localparam int OTPA_OPT_W       = 5;
   localparam int OTPA_OPT_PROTECT = 0;
   localparam int OTPA_OPT_LOWNOIS = 1;
   localparam int OTPA_OPT_LATCHDS = 2;
   localparam int OTPA_OPT_WDOG    = 3;
   localparam int OTPA_OPT_ACCDIS  = 4;
   localparam logic [OTPA_OPT_W-1:0] OTPA_OPT_RESET = 5'h0_0;
   localparam logic [OTPA_DW-1:0]    OTPA_ERASED    = 8'hf_f;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int OTPA_CLK_NS      = 10;
   localparam int OTPA_WDOG_MS     = 10;
   localparam int OTPA_WDOG_CYC    = (OTPA_WDOG_MS * 1000000 + OTPA_CLK_NS - 1) / OTPA_CLK_NS;
   localparam int OTPA_LN_MAX_MHZ  = 4;
   localparam int OTPA_LN_MIN_NS   = 250;
   localparam int OTPA_LN_DIV      = (OTPA_LN_MIN_NS + OTPA_CLK_NS - 1) / OTPA_CLK_NS;
   localparam int OTPA_SYNC_STAGES = 3;
   localparam int OTPA_STROBE_CYC  = 4;

endpackage : otpa_pkg

// ### otpa_if.sv
/*
 Interface joining the external programmer and the device's access pins.
 Resolves the shared data bus here from the two enables, the device end taking priority.
*/
`timescale 1ns/1ps
interface otpa_if;
   import otpa_pkg::*;
   otpa_level_t           osc_in_pin;
   otpa_level_t           port3_line1;
   otpa_level_t           port3_line2;
   otpa_level_t           port3_line3;
   otpa_level_t           port0_line2;
   logic [OTPA_AW-1:0]    addr;
   logic [OTPA_DW-1:0]    data_dev_o;
   logic                  data_dev_oe;
   logic [OTPA_DW-1:0]    data_prg_o;
   logic                  data_prg_oe;
   logic [OTPA_DW-1:0]    data_bus;

   assign data_bus = data_dev_oe ? data_dev_o : (data_prg_oe ? data_prg_o : '0);

   modport device (
      input  osc_in_pin,
      input  port3_line1,
      input  port3_line2,
      input  port3_line3,
      input  port0_line2,
      input  addr,
      input  data_prg_o,
      input  data_prg_oe,
      output data_dev_o,
      output data_dev_oe
   );

   modport programmer (
      output osc_in_pin,
      output port3_line1,
      output port3_line2,
      output port3_line3,
      output port0_line2,
      output addr,
      output data_prg_o,
      output data_prg_oe,
      input  data_dev_o,
      input  data_dev_oe
   );
endinterface : otpa_if

// ### otpa_device.sv
/*
 Device end: decodes access mode from the five reassigned pins, holds the program memory and option bits,
 and applies the options to run-time behaviour.
 Assumes pins arrive asynchronously and are synchronised here; power cycling is a reset.
*/
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module otpa_device
   import otpa_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               arst_n,
   otpa_if.device                  pins,
   input  wire logic               test_mode_req,
   input  wire logic [OTPA_AW-1:0] const_addr,
   input  wire logic               const_rd,
   output logic [OTPA_DW-1:0]      const_data,
   input  wire logic               wdog_sw_en,
   input  wire logic               wdog_kick,
   input  wire logic               halt_mode,
   input  wire logic               stop_mode,
   input  wire logic [2:0]         port_in_driven,
   input  wire logic [2:0]         port_in_level,
   output logic [2:0]              port_in_held,
   output logic                    sys_clk_en,
   output logic                    test_mode_active,
   output logic                    wdog_reset,
   output logic                    wdog_running,
   output logic [OTPA_OPT_W-1:0]   options_active
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 5;
   otpa_level_t pin_raw [NPIN];
   logic [1:0]  sync_r  [NPIN][OTPA_SYNC_STAGES];
   logic [1:0]  pin_r   [NPIN];

   assign pin_raw[0] = pins.osc_in_pin;
   assign pin_raw[1] = pins.port3_line1;
   assign pin_raw[2] = pins.port3_line2;
   assign pin_raw[3] = pins.port3_line3;
   assign pin_raw[4] = pins.port0_line2;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               sync_r[gi][0] <= 2'h0;
               sync_r[gi][1] <= 2'h0;
               sync_r[gi][2] <= 2'h0;
               pin_r[gi]     <= 2'h0;
            end else begin
               sync_r[gi][0] <= pin_raw[gi];
               sync_r[gi][1] <= sync_r[gi][0];
               sync_r[gi][2] <= sync_r[gi][1];
               if (sync_r[gi][1] == sync_r[gi][2])
                  pin_r[gi] <= sync_r[gi][2];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   function automatic otpa_op_t decode_op(input logic [1:0] ce, input logic [1:0] oe, input logic [1:0] sel,
                                          input logic [1:0] vpp, input logic [1:0] program_strobe_n);
      logic hv;
      logic lo_ce;
      logic lo_oe;
      hv    = (vpp == OTPA_LVL_HV);
      lo_ce = (ce == OTPA_LVL_LOW);
      lo_oe = (oe == OTPA_LVL_LOW);
      decode_op = OTPA_OP_IDLE;
      if (sel == OTPA_LVL_HV && lo_ce && lo_oe && program_strobe_n != OTPA_LVL_LOW)
         decode_op = OTPA_OP_READ;
      else if (hv && ce == OTPA_LVL_HV && program_strobe_n == OTPA_LVL_LOW) begin
         if (sel == OTPA_LVL_HV && !lo_oe)
            decode_op = OTPA_OP_SET_PROTECT;
         else if (sel == OTPA_LVL_HIGH)
            decode_op = lo_oe ? OTPA_OP_SET_LATCHDIS : OTPA_OP_SET_LOWNOISE;
         else if (sel == OTPA_LVL_LOW)
            decode_op = lo_oe ? OTPA_OP_SET_ACCDIS : OTPA_OP_SET_WDOG;
      end else if (hv && sel == OTPA_LVL_HIGH && lo_ce) begin
         if (!lo_oe && program_strobe_n == OTPA_LVL_LOW)
            decode_op = OTPA_OP_PROGRAM;
         else if (lo_oe && program_strobe_n != OTPA_LVL_LOW)
            decode_op = OTPA_OP_VERIFY;
      end
   endfunction : decode_op

   // Unprogrammed fuses and cells start erased; reset leaves both alone.
   logic [OTPA_OPT_W-1:0] opt_store_r = OTPA_OPT_RESET;
   logic [OTPA_OPT_W-1:0] opt_live_r;
   otpa_op_t              op;
   otpa_op_t              op_prev_r;
   logic                  acc_dis;

   assign acc_dis = opt_live_r[OTPA_OPT_ACCDIS];
   assign op = acc_dis ? OTPA_OP_IDLE
                       : decode_op(pin_r[0], pin_r[1], pin_r[2], pin_r[3], pin_r[4]);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         op_prev_r <= OTPA_OP_IDLE;
      else
         op_prev_r <= op;
   end

   // ----------------------------------------------------------------
   // Program memory and option fuses
   // ----------------------------------------------------------------
   logic [OTPA_DW-1:0] mem [OTPA_DEPTH] = '{default: OTPA_ERASED};
   logic               prog_edge;

   assign prog_edge = (op == OTPA_OP_PROGRAM) && (op_prev_r != OTPA_OP_PROGRAM);

   always_ff @(posedge clock) begin
      if (prog_edge)
         mem[pins.addr] <= mem[pins.addr] & pins.data_prg_o;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         const_data <= OTPA_ERASED;
      else if (const_rd)
         const_data <= mem[const_addr];
   end

   // Fuses survive reset in silicon; here they are only ever set, never cleared by logic.
   always_ff @(posedge clock) begin
      if (op != op_prev_r) begin
         case (op)
            OTPA_OP_SET_PROTECT:  opt_store_r[OTPA_OPT_PROTECT] <= 1'b1;
            OTPA_OP_SET_LOWNOISE: opt_store_r[OTPA_OPT_LOWNOIS] <= 1'b1;
            OTPA_OP_SET_LATCHDIS: opt_store_r[OTPA_OPT_LATCHDS] <= 1'b1;
            OTPA_OP_SET_WDOG:     opt_store_r[OTPA_OPT_WDOG]    <= 1'b1;
            OTPA_OP_SET_ACCDIS:   opt_store_r[OTPA_OPT_ACCDIS]  <= 1'b1;
            default: ;
         endcase
      end
   end

   logic rst_exit_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_exit_r <= 1'b1;
         opt_live_r <= OTPA_OPT_RESET;
      end else begin
         rst_exit_r <= 1'b0;
         if (rst_exit_r)
            opt_live_r <= opt_store_r;
      end
   end
   assign options_active   = opt_live_r;
   assign test_mode_active = test_mode_req && !acc_dis;

   // ----------------------------------------------------------------
   // Data drive
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pins.data_dev_o  <= 8'h0_0;
         pins.data_dev_oe <= 1'b0;
      end else begin
         pins.data_dev_oe <= 1'b0;
         if ((op == OTPA_OP_READ && !opt_live_r[OTPA_OPT_PROTECT]) || op == OTPA_OP_VERIFY) begin
            pins.data_dev_o  <= mem[pins.addr];
            pins.data_dev_oe <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock divide and low-noise limit
   // ----------------------------------------------------------------
   logic [5:0] div_r;
   logic [5:0] div_top;
   assign div_top = opt_live_r[OTPA_OPT_LOWNOIS] ? 6'(OTPA_LN_DIV - 1) : 6'(2 * OTPA_LN_DIV - 1);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         div_r <= 6'h0_0;
      else
         div_r <= (div_r >= div_top) ? 6'h0_0 : div_r + 6'h0_1;
   end
   assign sys_clk_en = (div_r == 6'h0_0);

   // ----------------------------------------------------------------
   // Input hold latches
   // ----------------------------------------------------------------
   logic [2:0] held_r;
   always_ff @(posedge clock) begin
      held_r <= (port_in_driven & port_in_level) | (~port_in_driven & held_r);
   end
   generate
      for (gi = 0; gi < 3; gi++) begin : g_latch
         assign port_in_held[gi] = (port_in_driven[gi] || opt_live_r[OTPA_OPT_LATCHDS])
                                   ? port_in_level[gi] : held_r[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   logic [20:0] wdog_cnt_r;
   logic        wdog_run;
   logic        wdog_sw_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         wdog_sw_r <= 1'b0;
      else if (wdog_sw_en)
         wdog_sw_r <= 1'b1;
   end
   assign wdog_run = opt_live_r[OTPA_OPT_WDOG]
                     || (wdog_sw_r && !halt_mode && !stop_mode);
   assign wdog_running = wdog_run;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wdog_cnt_r <= '0;
         wdog_reset <= 1'b0;
      end else begin
         wdog_reset <= 1'b0;
         if (wdog_kick || !wdog_run)
            wdog_cnt_r <= '0;
         else if (wdog_cnt_r == 21'(OTPA_WDOG_CYC - 1)) begin
            wdog_cnt_r <= '0;
            wdog_reset <= 1'b1;
         end else
            wdog_cnt_r <= wdog_cnt_r + 21'h0_1;
      end
   end

endmodule : otpa_device

// ### otpa_programmer.sv
/*
 Programmer end: turns one-cycle user commands into pin sequences for the device.
 Assumes the device end samples pins through three synchroniser flip-flops and one filter register.
*/
`timescale 1ns/1ps
module otpa_programmer
   import otpa_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               arst_n,
   otpa_if.programmer              pins,
   input  wire logic               cmd_valid,
   input  wire otpa_op_t           cmd_op,
   input  wire logic [OTPA_AW-1:0] cmd_addr,
   input  wire logic [OTPA_DW-1:0] cmd_data,
   output logic                    busy,
   output logic                    rsp_valid,
   output logic [OTPA_DW-1:0]      rsp_data
);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_DONE} otpa_pst_t;
   otpa_pst_t  st_r;
   otpa_op_t   op_r;
   logic [3:0] cnt_r;
   localparam logic [3:0] HOLD = 4'(OTPA_STROBE_CYC + OTPA_SYNC_STAGES + 2);

   assign busy = (st_r != ST_IDLE);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r      <= ST_IDLE;
         op_r      <= OTPA_OP_IDLE;
         cnt_r     <= 4'h0;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h0_0;
         pins.addr <= '0;
         pins.data_prg_o  <= 8'h0_0;
      end else begin
         rsp_valid <= 1'b0;
         case (st_r)
            ST_IDLE: if (cmd_valid) begin
               op_r      <= cmd_op;
               pins.addr <= cmd_addr;
               pins.data_prg_o <= cmd_data;
               cnt_r     <= 4'h0;
               st_r      <= ST_SETUP;
            end
            ST_SETUP: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == HOLD) begin
                  cnt_r <= 4'h0;
                  st_r  <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == HOLD) begin
                  if (pins.data_dev_oe)
                     rsp_data <= pins.data_dev_o;
                  else
                     rsp_data <= OTPA_ERASED;
                  cnt_r <= 4'h0;
                  st_r  <= ST_DONE;
               end
            end
            ST_DONE: begin
               // Setup levels stay until the device has seen the strobe end and released the data bus.
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == HOLD) begin
                  rsp_valid <= 1'b1;
                  op_r      <= OTPA_OP_IDLE;
                  st_r      <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin levels; idle parks every pin at a valid logic high
   // ----------------------------------------------------------------
   logic strobe;
   assign strobe = (st_r == ST_STROBE);

   always_comb begin
      pins.osc_in_pin  = OTPA_LVL_HIGH;
      pins.port3_line1 = OTPA_LVL_HIGH;
      pins.port3_line2 = OTPA_LVL_HIGH;
      pins.port3_line3 = OTPA_LVL_HIGH;
      pins.port0_line2 = OTPA_LVL_HIGH;
      pins.data_prg_oe = 1'b0;
      case (op_r)
         OTPA_OP_READ: begin
            pins.port3_line2 = OTPA_LVL_HV;
            pins.osc_in_pin  = strobe ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
            pins.port3_line1 = strobe ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
         end
         OTPA_OP_PROGRAM: begin
            pins.port3_line3 = OTPA_LVL_HV;
            pins.osc_in_pin  = OTPA_LVL_LOW;
            pins.port0_line2 = strobe ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
            pins.data_prg_oe = 1'b1;
         end
         OTPA_OP_VERIFY: begin
            pins.port3_line3 = OTPA_LVL_HV;
            pins.osc_in_pin  = OTPA_LVL_LOW;
            pins.port3_line1 = strobe ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
         end
         OTPA_OP_SET_PROTECT, OTPA_OP_SET_LOWNOISE, OTPA_OP_SET_LATCHDIS,
         OTPA_OP_SET_WDOG, OTPA_OP_SET_ACCDIS: begin
            pins.port3_line3 = OTPA_LVL_HV;
            pins.osc_in_pin  = OTPA_LVL_HV;
            pins.port3_line2 = (op_r == OTPA_OP_SET_PROTECT) ? OTPA_LVL_HV :
                               (op_r == OTPA_OP_SET_WDOG || op_r == OTPA_OP_SET_ACCDIS)
                               ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
            pins.port3_line1 = (op_r == OTPA_OP_SET_LATCHDIS || op_r == OTPA_OP_SET_ACCDIS)
                               ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
            pins.port0_line2 = strobe ? OTPA_LVL_LOW : OTPA_LVL_HIGH;
         end
         default: ;
      endcase
   end

endmodule : otpa_programmer

// ### otpa_assertions.sv
/*
 Checker for the access pins between programmer and device.
 Assumes the testbench instantiates it beside the interface and connects every signal by name.
*/
`timescale 1ns/1ps
module otpa_assertions
   import otpa_pkg::*;
(
   input wire logic               clock,
   input wire logic               arst_n,
   input otpa_level_t             osc_in_pin,
   input otpa_level_t             port3_line1,
   input otpa_level_t             port3_line2,
   input otpa_level_t             port3_line3,
   input otpa_level_t             port0_line2,
   input wire logic [OTPA_AW-1:0] addr,
   input wire logic [OTPA_DW-1:0] data_dev_o,
   input wire logic               data_dev_oe,
   input wire logic [OTPA_DW-1:0] data_prg_o,
   input wire logic               data_prg_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // -------------------------------------------------------------
   // Pin relations
   // -------------------------------------------------------------
   a_no_bus_fight: assert property (!(data_dev_oe && data_prg_oe))
      else $error("both ends drive the data bus");
   a_read_levels: assert property ($rose(data_dev_oe) |-> $past(osc_in_pin, 3) == OTPA_LVL_LOW
      && $past(port3_line1, 3) == OTPA_LVL_LOW && $past(port0_line2, 3) != OTPA_LVL_LOW)
      else $error("device drives data outside a read or verify");
   a_prog_levels: assert property (data_prg_oe |-> port3_line1 == OTPA_LVL_HIGH
      && port3_line3 == OTPA_LVL_HV && osc_in_pin == OTPA_LVL_LOW)
      else $error("programmer drives data outside a program cycle");
   a_option_quiet: assert property (osc_in_pin == OTPA_LVL_HV |-> !data_prg_oe && !data_dev_oe)
      else $error("data bus active during option programming");
   a_valid_levels: assert property (port0_line2 inside {OTPA_LVL_LOW, OTPA_LVL_HIGH, OTPA_LVL_HV}
      && port3_line1 inside {OTPA_LVL_LOW, OTPA_LVL_HIGH, OTPA_LVL_HV})
      else $error("control pin at an invalid level");
   a_strobe_hold: assert property ($changed(port0_line2) |=> $stable(port0_line2) [*8])
      else $error("strobe level changed too soon");
   a_addr_hold: assert property (data_dev_oe && $past(data_dev_oe) |-> $stable(addr))
      else $error("address moved while the device drives data");
   a_data_hold: assert property (data_prg_oe && $past(data_prg_oe) |-> $stable(data_prg_o))
      else $error("program data moved while driven");
endmodule : otpa_assertions

// ### otp_program_mode_and_options_test.sv
/*
 Testbench joining programmer and device ends through the pin interface.
 Assumes commands answer with rsp_valid and option effects need a reset.
*/
`timescale 1ns/1ps
module otp_program_mode_and_options_test
   import otpa_pkg::*;
;
   logic               clock;
   logic               arst_n;
   logic               cmd_valid;
   otpa_op_t           cmd_op;
   logic [OTPA_AW-1:0] cmd_addr;
   logic [OTPA_DW-1:0] cmd_data;
   logic               busy;
   logic               rsp_valid;
   logic [OTPA_DW-1:0] rsp_data;
   logic               test_mode_req;
   logic [OTPA_AW-1:0] const_addr;
   logic               const_rd;
   logic [OTPA_DW-1:0] const_data;
   logic               wdog_sw_en;
   logic               wdog_kick;
   logic               halt_mode;
   logic               stop_mode;
   logic [2:0]         port_in_driven;
   logic [2:0]         port_in_level;
   logic [2:0]         port_in_held;
   logic               sys_clk_en;
   logic               test_mode_active;
   logic               wdog_reset;
   logic               wdog_running;
   logic [OTPA_OPT_W-1:0] options_active;
   int                 fails;
   int                 n_tests;

   otpa_if pins_if ();
   otpa_device i_otpa_device (.clock(clock), .arst_n(arst_n), .pins(pins_if.device),
      .test_mode_req(test_mode_req), .const_addr(const_addr), .const_rd(const_rd), .const_data(const_data),
      .wdog_sw_en(wdog_sw_en), .wdog_kick(wdog_kick), .halt_mode(halt_mode), .stop_mode(stop_mode),
      .port_in_driven(port_in_driven), .port_in_level(port_in_level), .port_in_held(port_in_held),
      .sys_clk_en(sys_clk_en), .test_mode_active(test_mode_active), .wdog_reset(wdog_reset),
      .wdog_running(wdog_running), .options_active(options_active));
   otpa_programmer i_otpa_programmer (.clock(clock), .arst_n(arst_n), .pins(pins_if.programmer),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   otpa_assertions i_otpa_assertions (.clock(clock), .arst_n(arst_n), .osc_in_pin(pins_if.osc_in_pin),
      .port3_line1(pins_if.port3_line1), .port3_line2(pins_if.port3_line2),
      .port3_line3(pins_if.port3_line3), .port0_line2(pins_if.port0_line2), .addr(pins_if.addr),
      .data_dev_o(pins_if.data_dev_o), .data_dev_oe(pins_if.data_dev_oe),
      .data_prg_o(pins_if.data_prg_o), .data_prg_oe(pins_if.data_prg_oe));

   // -------------------------------------------------------------
   // Clock and helpers
   // -------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_flag(input logic got, input logic exp);
      chk_val({7'h00, got}, {7'h00, exp});
   endtask : chk_flag

   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
   endtask : do_reset

   task automatic run_cmd(input otpa_op_t op, input logic [9:0] a, input logic [7:0] d);
      bit got;
      got = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_addr  <= a;
      cmd_data  <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1;
      chk_flag(busy, 1'b1);
      for (int i = 0; i < 100 && !got; i++) begin
         @(posedge clock);
         #1;
         if (rsp_valid === 1'b1) got = 1;
      end
      if (!got) begin
         fails++;
         wrap_up();
      end
   endtask : run_cmd

   task automatic const_load(input logic [9:0] a);
      @(posedge clock);
      const_addr <= a;
      const_rd   <= 1'b1;
      @(posedge clock);
      const_rd   <= 1'b0;
      #1;
   endtask : const_load

   task automatic clk_period(output int n);
      n = 0;
      for (int i = 0; i < 200 && sys_clk_en !== 1'b1; i++) @(posedge clock) #1;
      for (int i = 0; i < 200 && (n == 0 || sys_clk_en !== 1'b1); i++) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask : clk_period

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      int per;
      fails = 0;
      n_tests = 0;
      arst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OTPA_OP_IDLE;
      cmd_addr = '0;
      cmd_data = '0;
      test_mode_req = 1'b1;
      const_addr = '0;
      const_rd = 1'b0;
      wdog_sw_en = 1'b0;
      wdog_kick = 1'b0;
      halt_mode = 1'b1;
      stop_mode = 1'b1;
      port_in_driven = 3'h7;
      port_in_level = 3'h5;
      do_reset();
      chk_val({3'h0, options_active}, 8'h00);
      chk_flag(test_mode_active, 1'b1);
      chk_flag(wdog_running, 1'b0);
      wdog_sw_en <= 1'b1;
      @(posedge clock);
      wdog_sw_en <= 1'b0;
      halt_mode  <= 1'b0;
      stop_mode  <= 1'b0;
      @(posedge clock);
      #1;
      chk_flag(wdog_running, 1'b1);
      halt_mode  <= 1'b1;
      stop_mode  <= 1'b1;
      #1;
      chk_flag(wdog_running, 1'b0);
      clk_period(per);
      chk_val(per[7:0], 8'h32);
      port_in_driven <= 3'h0;
      port_in_level  <= 3'h2;
      wdog_kick      <= 1'b1;
      repeat (2) @(posedge clock);
      wdog_kick      <= 1'b0;
      #1;
      chk_val({5'h00, port_in_held}, 8'h05);
      run_cmd(OTPA_OP_PROGRAM, 10'h001, 8'h5a);
      run_cmd(OTPA_OP_PROGRAM, 10'h3ff, 8'h3c);
      run_cmd(OTPA_OP_READ, 10'h001, 8'h00);
      chk_val(rsp_data, 8'h5a);
      run_cmd(OTPA_OP_VERIFY, 10'h3ff, 8'h00);
      chk_val(rsp_data, 8'h3c);
      run_cmd(OTPA_OP_PROGRAM, 10'h001, 8'h0f);
      run_cmd(OTPA_OP_VERIFY, 10'h001, 8'h00);
      chk_val(rsp_data, 8'h0a);
      run_cmd(OTPA_OP_SET_PROTECT, 10'h000, 8'h00);
      chk_val({3'h0, options_active}, 8'h00);
      do_reset();
      chk_val({3'h0, options_active}, 8'h01);
      clk_period(per);
      chk_val(per[7:0], 8'h32);
      run_cmd(OTPA_OP_READ, 10'h3ff, 8'h00);
      chk_val(rsp_data, 8'hff);
      const_load(10'h3ff);
      chk_val(const_data, 8'h3c);
      run_cmd(OTPA_OP_SET_LOWNOISE, 10'h000, 8'h00);
      run_cmd(OTPA_OP_SET_LATCHDIS, 10'h000, 8'h00);
      run_cmd(OTPA_OP_SET_WDOG, 10'h000, 8'h00);
      do_reset();
      chk_val({3'h0, options_active}, 8'h0f);
      clk_period(per);
      chk_val(per[7:0], 8'h19);
      chk_val({5'h00, port_in_held}, 8'h02);
      chk_flag(wdog_running, 1'b1);
      chk_flag(wdog_reset, 1'b0);
      run_cmd(OTPA_OP_SET_ACCDIS, 10'h000, 8'h00);
      chk_flag(test_mode_active, 1'b1);
      do_reset();
      chk_val({3'h0, options_active}, 8'h1f);
      chk_flag(test_mode_active, 1'b0);
      run_cmd(OTPA_OP_PROGRAM, 10'h002, 8'h00);
      run_cmd(OTPA_OP_VERIFY, 10'h001, 8'h00);
      chk_val(rsp_data, 8'hff);
      const_load(10'h002);
      chk_val(const_data, OTPA_ERASED);
      wrap_up();
   end
endmodule : otp_program_mode_and_options_test
